/* rtl/irqmc_ctrl.sv */
// Interrupt mode control word for sources 20 to 23 with APB access
`default_nettype none
// Overview of operation
// - Activation bit picks CPU interrupt or DMA
// - Level zero disables, one to seven prioritise
// - With DMA, level selects channel zero-three
// - One byte per source, fixed field layout
module irqmc_ctrl (
	input  wire logic                                          clk,
	input  wire logic                                          rst_n,
	input  wire logic                                          psel,
	input  wire logic                                          penable,
	input  wire logic                                          pwrite,
	input  wire logic [31:0]                                   paddr,
	input  wire logic [31:0]                                   pwdata,
	output var  logic [31:0]                                   prdata,
	output var  logic                                          pready,
	output var  logic                                          pslverr,
	input  wire logic [irqmc_pkg::IRQMC_NSRC-1:0]              srcReq,
	output var  logic [irqmc_pkg::IRQMC_NSRC-1:0]              intReq,
	output var  logic [irqmc_pkg::IRQMC_NSRC*irqmc_pkg::IRQMC_LVL_W-1:0]  intLevel,
	output var  logic [irqmc_pkg::IRQMC_NSRC-1:0]              dmaReq,
	output var  logic [irqmc_pkg::IRQMC_NSRC*irqmc_pkg::IRQMC_CHAN_W-1:0] dmaChan
);
	import irqmc_pkg::*;

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	logic [31:0] word_r;
	logic [31:0] word_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        pready_r;
	logic        pready_nxt;
	logic        pslverr_r;
	logic        pslverr_nxt;
	logic        hit;
	logic        setup;
	logic        commit;

	function automatic logic addrHit(input logic [31:0] a);
		addrHit = (a == IRQMC_ADDR);
	endfunction

	assign hit    = addrHit(paddr);
	assign setup  = psel && !penable;
	// Write lands only at the edge where the access completes
	assign commit = psel && penable && pready_r && pwrite && hit;

	always_comb begin
		word_nxt    = word_r;
		prdata_nxt  = 32'h00000000;
		pready_nxt  = 1'b0;
		pslverr_nxt = 1'b0;
		if (commit) begin
			word_nxt = pwdata & IRQMC_WMASK;
		end
		if (setup) begin
			pready_nxt  = 1'b1;
			pslverr_nxt = !hit;
			if (!pwrite && hit) begin
				prdata_nxt = word_r;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			word_r    <= IRQMC_RESET;
			prdata_r  <= 32'h00000000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			word_r    <= word_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;

	// ------------------------------------------------------------
	// Per-source routing
	// ------------------------------------------------------------
	logic [IRQMC_NSRC-1:0]              intReq_r;
	logic [IRQMC_NSRC-1:0]              intReq_nxt;
	logic [IRQMC_NSRC*IRQMC_LVL_W-1:0]  intLevel_r;
	logic [IRQMC_NSRC*IRQMC_LVL_W-1:0]  intLevel_nxt;
	logic [IRQMC_NSRC-1:0]              dmaReq_r;
	logic [IRQMC_NSRC-1:0]              dmaReq_nxt;
	logic [IRQMC_NSRC*IRQMC_CHAN_W-1:0] dmaChan_r;
	logic [IRQMC_NSRC*IRQMC_CHAN_W-1:0] dmaChan_nxt;

	genvar gi;
	generate
		for (gi = 0; gi < IRQMC_NSRC; gi++) begin : gSrc
			irqmc_route_if rif ();
			// Byte gi belongs to source 20+gi
			assign rif.cfg = word_r[gi*IRQMC_BYTE_W +: IRQMC_BYTE_W];
			assign rif.req = srcReq[gi];
			irqmc_src_route uRoute (
				.rif (rif)
			);
			assign intReq_nxt[gi]                              = rif.intReq;
			assign intLevel_nxt[gi*IRQMC_LVL_W +: IRQMC_LVL_W] = rif.intLevel;
			assign dmaReq_nxt[gi]                              = rif.dmaReq;
			assign dmaChan_nxt[gi*IRQMC_CHAN_W +: IRQMC_CHAN_W] = rif.dmaChan;

			property p_int_route;
				@(posedge clk) disable iff (!rst_n)
				(srcReq[gi] && !word_r[gi*IRQMC_BYTE_W+IRQMC_DMA_BIT]
				 && word_r[gi*IRQMC_BYTE_W+IRQMC_MODE_LSB +: IRQMC_MODE_W] == IRQMC_MODE_ON
				 && word_r[gi*IRQMC_BYTE_W +: IRQMC_LVL_W] != IRQMC_LVL_OFF)
				|=> intReq[gi] && !dmaReq[gi];
			endproperty
			a_int_route: assert property (p_int_route) else $error("interrupt not routed");

			property p_dma_route;
				@(posedge clk) disable iff (!rst_n)
				(srcReq[gi] && word_r[gi*IRQMC_BYTE_W+IRQMC_DMA_BIT]
				 && word_r[gi*IRQMC_BYTE_W+IRQMC_MODE_LSB +: IRQMC_MODE_W] == IRQMC_MODE_ON
				 && word_r[gi*IRQMC_BYTE_W +: IRQMC_LVL_W] <= IRQMC_CH_MAX)
				|=> dmaReq[gi] && !intReq[gi]
				 && dmaChan[gi*IRQMC_CHAN_W +: IRQMC_CHAN_W] == $past(word_r[gi*IRQMC_BYTE_W +: IRQMC_CHAN_W]);
			endproperty
			a_dma_route: assert property (p_dma_route) else $error("dma trigger missing");

			property p_level_off;
				@(posedge clk) disable iff (!rst_n)
				(word_r[gi*IRQMC_BYTE_W +: IRQMC_LVL_W] == IRQMC_LVL_OFF
				 && !word_r[gi*IRQMC_BYTE_W+IRQMC_DMA_BIT]) |=> !intReq[gi];
			endproperty
			a_level_off: assert property (p_level_off) else $error("disabled source raised");

			property p_level_copy;
				@(posedge clk) disable iff (!rst_n)
				$rose(intReq[gi]) |-> intLevel[gi*IRQMC_LVL_W +: IRQMC_LVL_W]
				 == $past(word_r[gi*IRQMC_BYTE_W +: IRQMC_LVL_W]);
			endproperty
			a_level_copy: assert property (p_level_copy) else $error("wrong priority level");

			property p_bad_chan;
				@(posedge clk) disable iff (!rst_n)
				(word_r[gi*IRQMC_BYTE_W+IRQMC_DMA_BIT]
				 && word_r[gi*IRQMC_BYTE_W +: IRQMC_LVL_W] > IRQMC_CH_MAX) |=> !dmaReq[gi] && !intReq[gi];
			endproperty
			a_bad_chan: assert property (p_bad_chan) else $error("invalid channel triggered");

			property p_mode_gate_src;
				@(posedge clk) disable iff (!rst_n)
				(word_r[gi*IRQMC_BYTE_W+IRQMC_MODE_LSB +: IRQMC_MODE_W] != IRQMC_MODE_ON)
				|=> !intReq[gi] && !dmaReq[gi];
			endproperty
			a_mode_gate_src: assert property (p_mode_gate_src) else $error("gated source raised");

			// Level output reads zero outside interrupt mode
			property p_level_idle;
				@(posedge clk) disable iff (!rst_n)
				(word_r[gi*IRQMC_BYTE_W+IRQMC_MODE_LSB +: IRQMC_MODE_W] != IRQMC_MODE_ON
				 || word_r[gi*IRQMC_BYTE_W+IRQMC_DMA_BIT])
				|=> intLevel[gi*IRQMC_LVL_W +: IRQMC_LVL_W] == IRQMC_LVL_OFF;
			endproperty
			a_level_idle: assert property (p_level_idle) else $error("stale priority level");

			property p_no_request;
				@(posedge clk) disable iff (!rst_n)
				!srcReq[gi] |=> !intReq[gi] && !dmaReq[gi];
			endproperty
			a_no_request: assert property (p_no_request) else $error("output without request");

			property p_int_only;
				@(posedge clk) disable iff (!rst_n)
				!word_r[gi*IRQMC_BYTE_W+IRQMC_DMA_BIT] |=> !dmaReq[gi];
			endproperty
			a_int_only: assert property (p_int_only) else $error("dma raised in interrupt mode");

			property p_dma_only;
				@(posedge clk) disable iff (!rst_n)
				word_r[gi*IRQMC_BYTE_W+IRQMC_DMA_BIT] |=> !intReq[gi];
			endproperty
			a_dma_only: assert property (p_dma_only) else $error("interrupt raised in dma mode");

			property p_chan_copy;
				@(posedge clk) disable iff (!rst_n)
				dmaReq[gi] |-> dmaChan[gi*IRQMC_CHAN_W +: IRQMC_CHAN_W]
				 == $past(word_r[gi*IRQMC_BYTE_W +: IRQMC_CHAN_W]);
			endproperty
			a_chan_copy: assert property (p_chan_copy) else $error("wrong dma channel");

			// Outputs follow inputs with no hidden state
			property p_route_hold;
				@(posedge clk) disable iff (!rst_n)
				($stable(word_r[gi*IRQMC_BYTE_W +: IRQMC_BYTE_W]) && $stable(srcReq[gi]))
				|=> $stable(intReq[gi]) && $stable(dmaReq[gi]);
			endproperty
			a_route_hold: assert property (p_route_hold) else $error("route changed without cause");
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			intReq_r   <= '0;
			intLevel_r <= '0;
			dmaReq_r   <= '0;
			dmaChan_r  <= '0;
		end else begin
			intReq_r   <= intReq_nxt;
			intLevel_r <= intLevel_nxt;
			dmaReq_r   <= dmaReq_nxt;
			dmaChan_r  <= dmaChan_nxt;
		end
	end

	assign intReq   = intReq_r;
	assign intLevel = intLevel_r;
	assign dmaReq   = dmaReq_r;
	assign dmaChan  = dmaChan_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_write_effect;
		@(posedge clk) disable iff (!rst_n)
		(psel && penable && pready && pwrite && paddr == IRQMC_ADDR) |=> word_r == ($past(pwdata) & IRQMC_WMASK);
	endproperty
	a_write_effect: assert property (p_write_effect) else $error("write not stored");

	property p_read_back;
		@(posedge clk) disable iff (!rst_n)
		(psel && !penable && !pwrite && paddr == IRQMC_ADDR) |=> pready && !pslverr && prdata == $past(word_r);
	endproperty
	a_read_back: assert property (p_read_back) else $error("read data wrong");

	property p_reserved_zero;
		@(posedge clk) disable iff (!rst_n)
		(word_r & ~IRQMC_WMASK) == 32'h00000000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_unmapped;
		@(posedge clk) disable iff (!rst_n)
		(psel && !penable && paddr != IRQMC_ADDR) |=> pready && pslverr && prdata == 32'h00000000 ##1 $stable(word_r);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access misanswered");

	property p_mode_gate;
		@(posedge clk) disable iff (!rst_n)
		(word_r[IRQMC_MODE_LSB +: IRQMC_MODE_W] != IRQMC_MODE_ON) |=> !intReq[0] && !dmaReq[0];
	endproperty
	a_mode_gate: assert property (p_mode_gate) else $error("source active without mode");

	// ------------------------------------------------------------
	// Reset and handshake checks
	// ------------------------------------------------------------
	// Zero wait states, so ready never stretches
	property p_ready_pulse;
		@(posedge clk) disable iff (!rst_n)
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

	property p_ready_cause;
		@(posedge clk) disable iff (!rst_n)
		pready |-> $past(psel && !penable);
	endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");

	property p_err_qualified;
		@(posedge clk) disable iff (!rst_n)
		pslverr |-> pready;
	endproperty
	a_err_qualified: assert property (p_err_qualified) else $error("error without ready");

	property p_rdata_idle;
		@(posedge clk) disable iff (!rst_n)
		!pready |-> prdata == 32'h00000000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");

	property p_read_keeps;
		@(posedge clk) disable iff (!rst_n)
		(psel && penable && !pwrite) |=> $stable(word_r);
	endproperty
	a_read_keeps: assert property (p_read_keeps) else $error("read altered the word");

	// Checked without disable so the reset values themselves are seen
	property p_reset_clear;
		@(posedge clk)
		!rst_n |=> word_r == IRQMC_RESET && !pready && !pslverr && intReq == '0 && dmaReq == '0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset left state behind");

	c_int:  cover property (@(posedge clk) disable iff (!rst_n) $rose(intReq[0]));
	c_dma:  cover property (@(posedge clk) disable iff (!rst_n) $rose(dmaReq[3]));
	c_wr:   cover property (@(posedge clk) disable iff (!rst_n) psel && penable && pready && pwrite);
	c_err:  cover property (@(posedge clk) disable iff (!rst_n) pready && pslverr);
	c_rd:   cover property (@(posedge clk) disable iff (!rst_n) psel && penable && pready && !pwrite);
endmodule
`default_nettype wire

/* rtl/irqmc_pkg.sv */
// Constants shared by the interrupt mode control word for sources 20 to 23
`default_nettype none
package irqmc_pkg;
	localparam int          IRQMC_NSRC     = 4;
	localparam int          IRQMC_BYTE_W   = 8;
	localparam int          IRQMC_LVL_LSB  = 0;
	localparam int          IRQMC_LVL_W    = 3;
	localparam int          IRQMC_DMA_BIT  = 3;
	localparam int          IRQMC_MODE_LSB = 4;
	localparam int          IRQMC_MODE_W   = 2;
	localparam int          IRQMC_CHAN_W   = 2;
	localparam logic [31:0] IRQMC_ADDR     = 32'hFFFFE014;
	localparam logic [31:0] IRQMC_RESET    = 32'h00000000;
	localparam logic [31:0] IRQMC_WMASK    = 32'h3F3F3F3F;
	localparam logic [1:0]  IRQMC_MODE_ON  = 2'h3;
	localparam logic [2:0]  IRQMC_LVL_OFF  = 3'h0;
	localparam logic [2:0]  IRQMC_CH_MAX   = 3'h3;
	typedef logic [IRQMC_BYTE_W-1:0] irqmc_cfg_t;
endpackage
`default_nettype wire

/* rtl/irqmc_route_if.sv */
// Carrier between the control word and one source router
`default_nettype none
interface irqmc_route_if;
	import irqmc_pkg::*;
	irqmc_cfg_t              cfg;
	logic                    req;
	logic                    intReq;
	logic [IRQMC_LVL_W-1:0]  intLevel;
	logic                    dmaReq;
	logic [IRQMC_CHAN_W-1:0] dmaChan;
	modport ctrl  (output cfg, output req, input intReq, input intLevel, input dmaReq, input dmaChan);
	modport route (input cfg, input req, output intReq, output intLevel, output dmaReq, output dmaChan);
endinterface
`default_nettype wire

/* rtl/irqmc_src_route.sv */
// Routing of one source request to the CPU or to a DMA channel
`default_nettype none
module irqmc_src_route (
	irqmc_route_if.route rif
);
	import irqmc_pkg::*;
	logic [IRQMC_LVL_W-1:0]  lvl;
	logic                    dmaOn;
	logic                    modeOk;

	assign lvl    = rif.cfg[IRQMC_LVL_LSB +: IRQMC_LVL_W];
	assign dmaOn  = rif.cfg[IRQMC_DMA_BIT];
	assign modeOk = (rif.cfg[IRQMC_MODE_LSB +: IRQMC_MODE_W] == IRQMC_MODE_ON);

	always_comb begin
		rif.intReq   = 1'b0;
		rif.intLevel = IRQMC_LVL_OFF;
		rif.dmaReq   = 1'b0;
		rif.dmaChan  = lvl[IRQMC_CHAN_W-1:0];
		if (modeOk && !dmaOn) begin
			rif.intLevel = lvl;
			rif.intReq   = rif.req && (lvl != IRQMC_LVL_OFF);
		end else if (modeOk && dmaOn) begin
			// Invalid channel codes trigger nothing
			rif.dmaReq = rif.req && (lvl <= IRQMC_CH_MAX);
		end
	end
endmodule
`default_nettype wire

/* verif/irqmc_far_model.sv */
// Model of the CPU interrupt intake and the DMA trigger side
`default_nettype none
module irqmc_far_model (
	input  wire logic [3:0]  intReq,
	input  wire logic [11:0] intLevel,
	input  wire logic [3:0]  dmaReq,
	input  wire logic [7:0]  dmaChan,
	output var  logic [2:0]  cpuLevel,
	output var  logic [3:0]  dmaHit
);
	timeunit 1ns;
	timeprecision 1ps;
	// Highest pending level wins; ties need no order here
	always_comb begin
		cpuLevel = 3'h0;
		dmaHit   = 4'h0;
		for (int i = 0; i < 4; i++) begin
			if (intReq[i] && intLevel[3*i+:3] > cpuLevel) cpuLevel = intLevel[3*i+:3];
			if (dmaReq[i]) dmaHit[dmaChan[2*i+:2]] = 1'b1;
		end
	end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the interrupt mode control word
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import irqmc_pkg::*;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, w;
	logic [3:0]  srcReq, intReq, dmaReq, dmaHit;
	logic [11:0] intLevel, lm;
	logic [7:0]  dmaChan, cm;
	logic [2:0]  cpuLevel;
	logic [63:0] aq[$], rq[$], e;
	int          fail_count, cmp_count, n;
	int          seed = 32'hc78d9f41;
	event        rchk;
	irqmc_ctrl DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.srcReq(srcReq), .intReq(intReq), .intLevel(intLevel), .dmaReq(dmaReq), .dmaChan(dmaChan));
	irqmc_far_model FAR (.intReq(intReq), .intLevel(intLevel), .dmaReq(dmaReq), .dmaChan(dmaChan),
		.cpuLevel(cpuLevel), .dmaHit(dmaHit));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("compares=%0d mismatches=%0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Bus master, one transfer then one idle cycle
	// ----------------------------------------
	task apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [31:0] ex);
		n = 0;
		aq.push_back({31'h0, a != IRQMC_ADDR, ex});
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk) penable <= 1'b1;
		do @(posedge clk) n++; while (pready !== 1'b1 && n < 20);
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			fail_count++;
			report_and_stop();
		end
		@(posedge clk);
	endtask
	always @(posedge clk) begin
		if (pready === 1'b1) chk({31'h0, pslverr, prdata}, aq.pop_front());
	end
	// Packs hit, top level, int, levels, dma, channels
	function automatic logic [63:0] mdl(input logic [31:0] wd, input logic [3:0] r);
		logic [63:0] x;
		logic [7:0]  b;
		logic        ok;
		x = 64'h0;
		for (int i = 0; i < 4; i++) begin
			b  = wd[8*i+:8];
			ok = r[i] && b[5:4] == IRQMC_MODE_ON;
			if (ok && !b[3] && b[2:0] != 3'h0) begin
				x[24+i]      = 1'b1;
				x[12+3*i+:3] = b[2:0];
				if (b[2:0] > x[30:28]) x[30:28] = b[2:0];
			end
			if (ok && b[3] && !b[2]) begin
				x[8+i]      = 1'b1;
				x[2*i+:2]   = b[1:0];
				x[31+b[1:0]] = 1'b1;
			end
		end
		return x;
	endfunction
	// Level and channel only matter where a request is expected
	always @(rchk) begin
		e = rq.pop_front();
		for (int i = 0; i < 4; i++) begin
			lm[3*i+:3] = {3{e[24+i]}};
			cm[2*i+:2] = {2{e[8+i]}};
		end
		chk({29'h0, dmaHit, cpuLevel, intReq, intLevel & lm, dmaReq, dmaChan & cm}, e);
	end
	task route(input logic [31:0] wd, input logic [3:0] r);
		apb(1'b1, IRQMC_ADDR, wd, 32'h0);
		apb(1'b0, IRQMC_ADDR, 32'h0, wd & IRQMC_WMASK);
		srcReq <= r;
		rq.push_back(mdl(wd, r));
		repeat (2) @(posedge clk);
		@(negedge clk) ->rchk;
		@(posedge clk);
	endtask
	initial begin
		rst_n   = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 32'h0;
		pwdata  = 32'h0;
		srcReq  = 4'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, IRQMC_ADDR, 32'h0, IRQMC_RESET);
		apb(1'b0, IRQMC_ADDR + 32'h4, 32'h0, 32'h0);
		apb(1'b1, 32'hFFFFE018, 32'h3F3F3F3F, 32'h0);
		apb(1'b0, IRQMC_ADDR, 32'h0, 32'h0);
		$display("register tests done");
		for (int k = 0; k < 24; k++) begin
			w = $random(seed);
			if (k % 2 == 1) w = w | 32'h30303030;
			if (k == 0) w = 32'h3A053035;
			if (k == 1) w = 32'h3B383433;
			// Software never pairs DMA with channel codes above three
			for (int i = 0; i < 4; i++) begin
				if (w[8*i+3]) w[8*i+2] = 1'b0;
			end
			route(w, k < 2 ? 4'hF : 4'($random(seed)));
			$display("route test %0d done", k);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
